// ### inc/kbd_glue_pkg.sv
`default_nettype none
package kbd_glue_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_KBD_RESET_GATE_CONFIG = 8'hf0;
  localparam logic [7:0] OFS_FAST_GATE_RESET_CTRL  = 8'h92;
  localparam logic [7:0] OFS_WAKE_STATUS           = 8'h10;
  localparam logic [7:0] OFS_WAKE_ENABLE           = 8'h11;
  localparam logic [7:0] OFS_KBC_PORT2             = 8'h12;
  // Config register fields
  localparam int CFG_FAST_EN_BIT   = 2;
  localparam int CFG_KBD_IRQ_LATCH_SEL_BIT    = 3;
  localparam int CFG_MOUSE_IRQ_LATCH_SEL_BIT    = 4;
  localparam int CFG_KISO_BIT      = 5;
  localparam int CFG_MISO_BIT      = 6;
  localparam int CFG_KRST_POL_BIT  = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Fast control register fields
  localparam int FAST_RST_BIT      = 0;
  localparam int FAST_A20_BIT      = 1;
  localparam logic [7:0] FAST_RO_ONES = 8'h24;
  // Wake fields: status/enable bits 0..3, global enable bit 7
  localparam int WAKE_KIRQ = 0;
  localparam int WAKE_MIRQ = 1;
  localparam int WAKE_KBD_DATA_LINE = 2;
  localparam int WAKE_MOUSE_DATA_LINE = 3;
  localparam int WAKE_GLOBAL_BIT = 7;
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int RST_DELAY_US   = 14;
  localparam int RST_PULSE_US   = 6;
  localparam int RST_DELAY_CYC  = RST_DELAY_US * CLK_MHZ;
  localparam int RST_PULSE_CYC  = RST_PULSE_US * CLK_MHZ;
  localparam int CNT_W          = 11;

  typedef struct packed {
    logic clk;
    logic dat;
  } ps_lines_t;
endpackage
`default_nettype wire

// ### src/line_sync.sv
`default_nettype none
module line_sync
  import kbd_glue_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // Two stages; first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### src/fast_a20_reset_kbd_wake_glue.sv
// Functional notes
// - Address mask low only if both gates low
// - Fast control bit 1 drives gate level
// - Fast gate control low after reset
// - Reset bit: 14us delay, 6us low pulse
// - No new pulse until bit returns 0
// - Reset clears bit 0, reset output high
// - Enabled pulse ANDed with controller reset, polarity
// - Mouse latch select chooses irq form
// - Keyboard latch select chooses irq form
// - Four events set wake status bits
// - Wake needs status, enable, global enable
// - Irq wakes need main power only
// - Mouse isolation blocks lines, not wake
// - Keyboard isolation blocks lines, not wake
`default_nettype none
module fast_a20_reset_kbd_wake_glue
  import kbd_glue_pkg::*;
#(
  parameter int DELAY_CYC = RST_DELAY_CYC,
  parameter int PULSE_CYC = RST_PULSE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       kbc_gate_out,
  input  wire logic       kbc_reset_n,
  input  wire logic       cpu_reset_in,
  input  wire logic       kbc_kbd_irq,
  input  wire logic       kbc_mouse_irq,
  input  wire logic       main_power_ok,
  input  wire ps_lines_t  kbd_pins,
  input  wire ps_lines_t  mouse_pins,
  output ps_lines_t       kbd_to_kbc,
  output ps_lines_t       mouse_to_kbc,
  output logic            cpu_addr_mask_n,
  output logic            fast_gate_ctl,
  output logic            soft_cpu_reset_n,
  output logic            kbd_reset_pin,
  output logic            kbd_irq,
  output logic            mouse_irq,
  output logic            wake_event
);
  typedef enum logic [1:0] {IDLE, WAIT_DLY, PULSE, HOLD} rst_st_t;

  logic [7:0] cfg_r, cfg_nxt;
  logic       a20_r, a20_nxt;
  logic       rbit_r, rbit_nxt;
  rst_st_t    st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] wsts_r, wsts_nxt;
  logic [4:0] wen_r, wen_nxt;
  logic [7:0] rdata_nxt;
  logic       klat_r, mlat_r, klat_nxt, mlat_nxt;
  logic       kbd_data_line_d_r, mouse_data_line_d_r;
  logic [3:0] pins_s;
  logic       fast_en, kedge, medge;
  logic [3:0] ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  line_sync #(.WIDTH(4)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({kbd_pins.clk, kbd_pins.dat, mouse_pins.clk, mouse_pins.dat}),
    .sync_out (pins_s)
  );

  assign fast_en = cfg_r[CFG_FAST_EN_BIT];

  always_comb begin
    cfg_nxt  = cfg_r;
    a20_nxt  = a20_r;
    rbit_nxt = rbit_r;
    wen_nxt  = wen_r;
    if (reg_wr && hit(reg_addr, OFS_KBD_RESET_GATE_CONFIG)) begin
      cfg_nxt = reg_wdata;
    end
    // Fast register exists only while enabled
    if (reg_wr && fast_en && hit(reg_addr, OFS_FAST_GATE_RESET_CTRL)) begin
      a20_nxt  = reg_wdata[FAST_A20_BIT];
      rbit_nxt = reg_wdata[FAST_RST_BIT];
    end
    if (reg_wr && hit(reg_addr, OFS_WAKE_ENABLE)) begin
      wen_nxt = {reg_wdata[WAKE_GLOBAL_BIT], reg_wdata[3:0]};
    end
  end

  // Pulse sequencer; HOLD blocks re-arm until bit 0 is cleared
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      IDLE: begin
        if (rbit_r) begin
          st_nxt  = WAIT_DLY;
          cnt_nxt = CNT_W'(DELAY_CYC - 1);
        end
      end
      WAIT_DLY: begin
        if (cnt_r == '0) begin
          st_nxt  = PULSE;
          cnt_nxt = CNT_W'(PULSE_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      PULSE: begin
        if (cnt_r == '0) begin
          st_nxt = HOLD;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      HOLD: begin
        if (!rbit_r) begin
          st_nxt = IDLE;
        end
      end
    endcase
  end

  // Interrupt latches capture controller irq edges, cleared when irq drops
  always_comb begin
    klat_nxt = kbc_kbd_irq ? (klat_r | 1'b1) : 1'b0;
    mlat_nxt = kbc_mouse_irq ? (mlat_r | 1'b1) : 1'b0;
  end

  assign kedge = kbd_data_line_d_r & ~pins_s[2];
  assign medge = mouse_data_line_d_r & ~pins_s[0];
  assign ev = {medge, kedge,
               mouse_irq & main_power_ok,
               kbd_irq & main_power_ok};

  always_comb begin
    wsts_nxt = wsts_r;
    // Write one clears; a new event in the same cycle wins
    if (reg_wr && hit(reg_addr, OFS_WAKE_STATUS)) begin
      wsts_nxt = wsts_r & ~reg_wdata[3:0];
    end
    wsts_nxt = wsts_nxt | ev;
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, OFS_KBD_RESET_GATE_CONFIG)) begin
        rdata_nxt = cfg_r;
      end else if (fast_en && hit(reg_addr, OFS_FAST_GATE_RESET_CTRL)) begin
        rdata_nxt = FAST_RO_ONES | {6'h00, a20_r, rbit_r};
      end else if (hit(reg_addr, OFS_WAKE_STATUS)) begin
        rdata_nxt = {4'h0, wsts_r};
      end else if (hit(reg_addr, OFS_WAKE_ENABLE)) begin
        rdata_nxt = {wen_r[4], 3'h0, wen_r[3:0]};
      end else if (hit(reg_addr, OFS_KBC_PORT2)) begin
        rdata_nxt = {6'h00, kbc_gate_out, kbc_reset_n};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r     <= CFG_RESET;
      a20_r     <= 1'b0;
      rbit_r    <= 1'b0;
      st_r      <= IDLE;
      cnt_r     <= '0;
      wsts_r    <= '0;
      wen_r     <= '0;
      klat_r    <= 1'b0;
      mlat_r    <= 1'b0;
      kbd_data_line_d_r  <= 1'b0;
      mouse_data_line_d_r  <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      cfg_r     <= cfg_nxt;
      a20_r     <= a20_nxt;
      rbit_r    <= rbit_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      wsts_r    <= wsts_nxt;
      wen_r     <= wen_nxt;
      klat_r    <= klat_nxt;
      mlat_r    <= mlat_nxt;
      kbd_data_line_d_r  <= pins_s[2];
      mouse_data_line_d_r  <= pins_s[0];
      reg_rdata <= rdata_nxt;
    end
  end

  assign fast_gate_ctl    = a20_r;
  // CPU reset input also forces the mask high
  assign cpu_addr_mask_n  = kbc_gate_out | a20_r | cpu_reset_in;
  assign soft_cpu_reset_n = (st_r != PULSE);
  // Config bit 0 selects inverted pin polarity
  assign kbd_reset_pin = cfg_r[CFG_KRST_POL_BIT] ^
    (kbc_reset_n & (soft_cpu_reset_n | ~fast_en));
  assign kbd_irq   = cfg_r[CFG_KBD_IRQ_LATCH_SEL_BIT] ? klat_r
                                           : (kbc_kbd_irq & klat_r);
  assign mouse_irq = cfg_r[CFG_MOUSE_IRQ_LATCH_SEL_BIT] ? mlat_r
                                           : (kbc_mouse_irq & mlat_r);
  assign wake_event = wen_r[4] & |(wsts_r & wen_r[3:0]);
  // Isolation only gates the controller side; wake uses raw samples
  assign kbd_to_kbc.clk   = pins_s[3] | cfg_r[CFG_KISO_BIT];
  assign kbd_to_kbc.dat   = pins_s[2] | cfg_r[CFG_KISO_BIT];
  assign mouse_to_kbc.clk = pins_s[1] | cfg_r[CFG_MISO_BIT];
  assign mouse_to_kbc.dat = pins_s[0] | cfg_r[CFG_MISO_BIT];

  a_mask_low: assert property (@(posedge core_clk) disable iff (rst)
    (!kbc_gate_out && !a20_r && !cpu_reset_in) |-> !cpu_addr_mask_n)
    else $error("address mask wrong");
  a_gate_write: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && fast_en && reg_addr == OFS_FAST_GATE_RESET_CTRL)
      |=> fast_gate_ctl == $past(reg_wdata[1]))
    else $error("fast gate not written");
  sequence s_arm;
    $rose(rbit_r) && st_r == IDLE;
  endsequence
  a_reset_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_arm |=> soft_cpu_reset_n [*8])
    else $error("reset pulse too early");
  a_reset_pulse: assert property (@(posedge core_clk) disable iff (rst)
    $fell(soft_cpu_reset_n) |-> !soft_cpu_reset_n [*8])
    else $error("reset pulse too short");
  a_no_rearm: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == HOLD && rbit_r) |=> st_r == HOLD)
    else $error("rearmed without clear");
  a_wake_gate: assert property (@(posedge core_clk) disable iff (rst)
    wake_event |-> wen_r[4] && (wsts_r & wen_r[3:0]) != 4'h0)
    else $error("wake without enable");
  a_kedge_sets: assert property (@(posedge core_clk) disable iff (rst)
    kedge |=> wsts_r[WAKE_KBD_DATA_LINE])
    else $error("key data edge lost");
  a_kiso_block: assert property (@(posedge core_clk) disable iff (rst)
    cfg_r[CFG_KISO_BIT] |-> kbd_to_kbc.clk && kbd_to_kbc.dat)
    else $error("keyboard not isolated");
  a_miso_block: assert property (@(posedge core_clk) disable iff (rst)
    cfg_r[CFG_MISO_BIT] |-> mouse_to_kbc.clk && mouse_to_kbc.dat)
    else $error("mouse not isolated");
  a_kbd_irq_latch_sel_sel: assert property (@(posedge core_clk) disable iff (rst)
    cfg_r[CFG_KBD_IRQ_LATCH_SEL_BIT] |-> kbd_irq == klat_r)
    else $error("kbd latch select");
endmodule
`default_nettype wire

// ### verification/kbc_model.sv
`default_nettype none
module kbc_model
  import kbd_glue_pkg::*;
(
  input  wire logic      core_clk,
  output var  logic [7:0] lines
);
  // Order: gate, reset_n, kbd irq, mouse irq, kbd clk/dat, mouse clk/dat
  // Pins idle high, as the external pull-ups leave them
  initial lines = 8'h4f;
  // Changes only just after an edge, like the real controller outputs
  task automatic drive(input logic [7:0] v);
    @(posedge core_clk);
    lines <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/fast_a20_reset_kbd_wake_glue_bench.sv
`default_nettype none
module fast_a20_reset_kbd_wake_glue_bench
  import kbd_glue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run brief
  localparam int DLY = 10;
  localparam int PLS = 10;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       cpu_rst = 1'b0;
  logic       pwr_ok = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] kl;
  logic       mask_n, a20, soft_n, kpin, kirq, mirq, wake;
  ps_lines_t  k2c, m2c;
  int         error_cnt = 0;
  int         compares = 0;

  always #4 core_clk = ~core_clk;

  kbc_model i_kbc (.core_clk(core_clk), .lines(kl));

  fast_a20_reset_kbd_wake_glue #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) i_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .kbc_gate_out(kl[7]), .kbc_reset_n(kl[6]),
    .cpu_reset_in(cpu_rst), .kbc_kbd_irq(kl[5]), .kbc_mouse_irq(kl[4]),
    .main_power_ok(pwr_ok), .kbd_pins(kl[3:2]), .mouse_pins(kl[1:0]),
    .kbd_to_kbc(k2c), .mouse_to_kbc(m2c), .cpu_addr_mask_n(mask_n),
    .fast_gate_ctl(a20), .soft_cpu_reset_n(soft_n),
    .kbd_reset_pin(kpin), .kbd_irq(kirq), .mouse_irq(mirq),
    .wake_event(wake));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic t_gate();
    rd(8'hf0, 8'h00);
    rd(8'h55, 8'h00);
    #1 chk({5'h0, a20, soft_n, wake}, 8'h02);
    wr(8'h92, 8'h02);
    rd(8'h92, 8'h00);
    wr(8'hf0, 8'h04);
    for (int i = 0; i < 4; i++) begin
      i_kbc.drive(i[1] ? 8'hcf : 8'h4f);
      wr(8'h92, {6'h0, i[0], 1'b0});
      #1 chk({a20, mask_n}, {i[0], i != 0});
    end
    rd(8'h92, 8'h26);
    // Gate and fast control low, so only the CPU reset can lift the mask
    i_kbc.drive(8'h4f);
    wr(8'h92, 8'h00);
    #1 chk(8'(mask_n), 8'h00);
    cpu_rst <= 1'b1;
    @(posedge core_clk);
    #1 chk(8'(mask_n), 8'h01);
    cpu_rst <= 1'b0;
  endtask

  task automatic t_pulse(input logic pin_exp);
    int n;
    int w;
    n = 0;
    w = 0;
    wr(8'h92, 8'h01);
    while (soft_n === 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(8'(n >= DLY && n <= DLY + 3), 8'h01);
    chk(8'(kpin), 8'(pin_exp));
    while (soft_n === 1'b0 && w < 100) begin
      @(posedge core_clk);
      #1 w++;
    end
    chk(8'(w >= PLS && w < 100), 8'h01);
    // Writing 1 again must not start another pulse
    wr(8'h92, 8'h01);
    for (int i = 0; i < DLY + PLS + 4; i++) begin
      @(posedge core_clk);
      #1 if (soft_n !== 1'b1) chk(8'(soft_n), 8'h01);
    end
    wr(8'h92, 8'h00);
  endtask

  task automatic t_latch(input logic [7:0] cfg, input logic held);
    wr(8'hf0, cfg);
    i_kbc.drive(8'h7f);
    repeat (3) @(posedge core_clk);
    #1 chk({kirq, mirq}, 8'h03);
    i_kbc.drive(8'h4f);
    #1 chk({kirq, mirq}, {held, held});
    repeat (3) @(posedge core_clk);
    #1 chk({kirq, mirq}, 8'h00);
  endtask

  task automatic t_wake();
    wr(8'hf0, 8'h00);
    wr(8'h11, 8'h8f);
    wr(8'h10, 8'h0f);
    i_kbc.drive(8'h6f);
    repeat (3) @(posedge core_clk);
    #1 chk(8'(wake), 8'h01);
    rd(8'h10, 8'h01);
    i_kbc.drive(8'h4f);
    wr(8'h10, 8'h01);
    wr(8'h11, 8'h0f);
    i_kbc.drive(8'h5f);
    repeat (3) @(posedge core_clk);
    rd(8'h10, 8'h02);
    chk(8'(wake), 8'h00);
    i_kbc.drive(8'h4f);
    wr(8'h10, 8'h0f);
    pwr_ok <= 1'b0;
    wr(8'h11, 8'h8f);
    i_kbc.drive(8'h5f);
    repeat (4) @(posedge core_clk);
    #1 chk(8'(wake), 8'h00);
    i_kbc.drive(8'h4f);
    wr(8'h10, 8'h0f);
    // Isolated lines still feed the wake logic on standby power
    wr(8'hf0, 8'h60);
    i_kbc.drive(8'h4a);
    repeat (5) @(posedge core_clk);
    #1 chk({k2c, m2c, 3'h0, wake}, 8'hf1);
    rd(8'h10, 8'h0c);
    wr(8'hf0, 8'h00);
    #1 chk({k2c, m2c, 4'h0}, 8'ha0);
    // Controller reset output low pulls the keyboard reset pin low, then releases it
    i_kbc.drive(8'h0a);
    #1 chk(8'(kpin), 8'h00);
    i_kbc.drive(8'h4a);
    #1 chk(8'(kpin), 8'h01);
    pwr_ok <= 1'b1;
  endtask

  task automatic give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_gate();
    t_pulse(1'b0);
    wr(8'hf0, 8'h05);
    t_pulse(1'b1);
    t_latch(8'h00, 1'b0);
    t_latch(8'h18, 1'b1);
    t_wake();
    give_verdict();
  end
endmodule
`default_nettype wire
